// *** pdmc_core_model.sv ***
// model of the core, interrupt sources and reset/standby pins
`timescale 1ns/1ps
module pdmc_core_model (
  input wire logic clk, // system clock
  output logic halt_strobe, // halt instruction executed
  output logic irq_pending, // enabled interrupt request
  output logic ext_wake, // external wake interrupt
  output logic int_reset_event, // internal reset source
  output logic reset_pin_n, // reset pin, low active
  output logic standby_pin_n // standby pin, low active
);
  // pins idle high, requests idle low from time zero
  initial begin
    halt_strobe = 1'b0;
    irq_pending = 1'b0;
    ext_wake = 1'b0;
    int_reset_event = 1'b0;
    reset_pin_n = 1'b1;
    standby_pin_n = 1'b1;
  end

  // the core raises halt for exactly one cycle per instruction
  task automatic halt();
    @(posedge clk);
    halt_strobe <= 1'b1;
    @(posedge clk);
    halt_strobe <= 1'b0;
  endtask

  // one-cycle request pulses; sel picks irq, wake or reset event
  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: irq_pending <= 1'b1;
      1: ext_wake <= 1'b1;
      default: int_reset_event <= 1'b1;
    endcase
    @(posedge clk);
    irq_pending <= 1'b0;
    ext_wake <= 1'b0;
    int_reset_event <= 1'b0;
  endtask

  // pin levels change only right after an edge
  task automatic pins(input logic rst_n, input logic standby_pin_n_n);
    @(posedge clk);
    reset_pin_n <= rst_n;
    standby_pin_n <= standby_pin_n_n;
  endtask
endmodule

// *** pdmc_pkg.sv ***
// package of constants and types for the power-down mode controller
// What this block and its software do
// R01: halt with select 0 enters sleep
// R02: halt with select 1 enters software standby
// R03: select bit survives standby wake-up
// R04: settle wait with oscillator running
// R05: settle field picks 8K to 128K states
// R06: flash variant code 101 gives 1,024
// R07: software picks settle time of 8 ms
// R08: short settle flagged as timer hazard
// R09: software restores settle code after wake
// R10: system control register layout and reset
// R11: interrupt, reset or standby pin ends sleep
// R12: wake interrupt, settle, then exception start
// R13: low standby pin forces hardware standby
// R14: halt strobe samples the select bit
package pdmc_pkg;

  // register map, byte address on the apb bus
  localparam logic [15:0] SYSCTL_ADDR = 16'hffc4;
  localparam logic [7:0] SYSCTL_RESET = 8'h09;

  // field positions inside system_control
  localparam int BIT_STANDBY_SEL = 7;
  localparam int BIT_SETTLE_LO = 4;
  localparam int BIT_RESET_SRC = 3;
  localparam int BIT_EDGE_SEL = 2;
  localparam int BIT_HOST_EN = 1;
  localparam int BIT_RAM_EN = 0;

  // settle field codes
  localparam logic [2:0] SETTLE_CODE_LONG = 3'h4;
  localparam logic [2:0] SETTLE_CODE_SHORT = 3'h5;

  // settle wait in system clock states
  localparam int SETTLE_BASE_CYCLES = 8192;
  localparam int SETTLE_SHORT_CYCLES = 1024;
  localparam int SETTLE_CNT_W = 18;

  // least crystal settle time, kept by software
  localparam int XTAL_SETTLE_MS = 8;

  // register image, bit 7 down to bit 0
  typedef struct packed {
    logic standby_select_bit;
    logic settle_sel_2;
    logic settle_sel_1;
    logic settle_sel_0;
    logic reset_source_flag;
    logic nonmaskable_edge_select;
    logic host_interface_enable;
    logic ram_enable_bit;
  } pdmc_sysctl_s;

  // operating states of the controller
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_SW_STANDBY,
    ST_SETTLE,
    ST_HW_STANDBY
  } pdmc_state_e;

endpackage

// *** pdmc_settle.sv ***
// oscillator settle timer used on wake-up from software standby
`timescale 1ns/1ps
module pdmc_settle #(
  parameter int BASE_CYCLES = pdmc_pkg::SETTLE_BASE_CYCLES, // code 000 wait
  parameter int SHORT_CYCLES = pdmc_pkg::SETTLE_SHORT_CYCLES, // code 101
  parameter bit FLASH_VARIANT = 1'b1 // flash part decodes code 101
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // synchronous reset, low active
  input wire logic start, // one-cycle pulse, begins the wait
  input wire logic [2:0] code, // settle field
  output logic busy, // wait in progress
  output logic done // one-cycle pulse at end of wait
);

  localparam int W = pdmc_pkg::SETTLE_CNT_W;

  // settle code to wait length in cycles
  function automatic logic [W-1:0] settle_cycles(input logic [2:0] c);
    logic [W-1:0] n;
    n = W'(BASE_CYCLES) << 4;
    if (c[2] == 1'b0) begin
      n = W'(BASE_CYCLES) << c[1:0];
    end else if (FLASH_VARIANT && c == pdmc_pkg::SETTLE_CODE_SHORT) begin
      n = W'(SHORT_CYCLES); // R06
    end
    // unused codes fall back to the longest wait, the safe side
    return n;
  endfunction

  logic [W-1:0] count; // cycles left minus one
  logic [W-1:0] next_count;
  logic next_busy;
  logic next_done;

  // load on start, count down, pulse done on the last cycle
  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      next_count = settle_cycles(code) - W'(1); // R05
      next_busy = 1'b1;
    end else if (busy) begin
      if (count == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

  // helper: wait length seen from start to done
  logic [W-1:0] elapsed;
  logic [W-1:0] expect_len;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      elapsed <= '0;
      expect_len <= '0;
    end else if (start) begin
      elapsed <= W'(1);
      expect_len <= settle_cycles(code);
    end else if (busy) begin
      elapsed <= elapsed + W'(1);
    end
  end

  AST_SETTLE_LEN: assert property ( // R05
    @(posedge clk) disable iff (!reset_n)
    done |-> elapsed == expect_len + W'(1))
    else $error("settle wait length wrong");

  AST_SHORT_CODE: assert property ( // R06
    @(posedge clk) disable iff (!reset_n)
    start && code == pdmc_pkg::SETTLE_CODE_SHORT
    |=> count == (FLASH_VARIANT ? W'(SHORT_CYCLES - 1)
                                : (W'(BASE_CYCLES) << 4) - W'(1)))
    else $error("code 101 decoded wrong");

endmodule

// *** pdmc_tb.sv ***
// self-checking bench for the power-down mode controller
`timescale 1ns/1ps
module testbench;
  localparam int BASE = 16; // shortened code 000 wait
  localparam int SHORT = 4; // shortened code 101 wait
  logic clk = 1'b0; // system clock
  logic reset_n = 1'b0; // synchronous reset
  logic [15:0] paddr = 16'h0000; // apb address
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb enable
  logic pwrite = 1'b0; // apb direction
  logic [31:0] pwdata = 32'h0000_0000; // apb write data
  logic [3:0] pstrb = 4'hf; // apb strobes
  logic [31:0] prdata; // apb read data
  logic pready, pslverr; // apb answer
  logic halt_strobe, irq_pending, ext_wake, int_reset_event;
  logic reset_pin_n, standby_pin_n; // pins from the model
  logic cpu_halt, cpu_reset, sys_clk_en, osc_en, module_reset;
  logic ports_hiz, irq_exception, ram_enable, host_if_enable;
  logic nmi_rising_edge, timer_div_limit;
  logic [2:0] power_state; // current mode
  logic [31:0] q_data; // last read data
  logic q_err; // last error flag
  logic held; // settle outputs stayed in standby
  int error_cnt = 0;
  int comparisons = 0;
  int n;

  pdmc_top #(.SETTLE_BASE(BASE), .SETTLE_SHORT(SHORT),
    .FLASH_VARIANT(1'b1)) i_dut (.clk(clk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_strobe(halt_strobe),
    .irq_pending(irq_pending), .ext_wake(ext_wake),
    .int_reset_event(int_reset_event), .reset_pin_n(reset_pin_n),
    .standby_pin_n(standby_pin_n), .cpu_halt(cpu_halt),
    .cpu_reset(cpu_reset), .sys_clk_en(sys_clk_en), .osc_en(osc_en),
    .module_reset(module_reset), .ports_hiz(ports_hiz),
    .irq_exception(irq_exception), .ram_enable(ram_enable),
    .host_if_enable(host_if_enable), .nmi_rising_edge(nmi_rising_edge),
    .timer_div_limit(timer_div_limit), .power_state(power_state));

  pdmc_core_model i_core (.clk(clk), .halt_strobe(halt_strobe),
    .irq_pending(irq_pending), .ext_wake(ext_wake),
    .int_reset_event(int_reset_event), .reset_pin_n(reset_pin_n),
    .standby_pin_n(standby_pin_n));

  // 10 mhz system clock
  always #50 clk = ~clk;

  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one apb transfer; the request stands until pready is sampled high, at most 50 edges
  task automatic apb(input logic [15:0] a, input logic w,
      input logic [7:0] d, input logic [3:0] s);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // a missing answer is a mismatch, not a silent pass
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: no apb answer", $time);
    end
    q_data = prdata;
    q_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read and compare data and error flag
  task automatic rd(input logic [15:0] a, input logic [7:0] exp,
      input logic err);
    apb(a, 1'b0, 8'h00, 4'hf);
    check(q_data, {24'h00_0000, exp});
    check({31'h0000_0000, q_err}, {31'h0000_0000, err});
  endtask

  // expected settle length, code 11x taken as the longest wait
  function automatic int settle_n(input logic [2:0] c);
    if (c == 3'h5) return SHORT;
    if (c > 3'h4) return BASE << 4;
    return BASE << c;
  endfunction

  // look at mode outputs one edge after the launching edge
  task automatic mode_chk(input logic [2:0] st, input logic [3:0] o);
    @(posedge clk);
    check({29'h0000_0000, power_state}, {29'h0000_0000, st});
    check({28'h000_0000, cpu_halt, sys_clk_en, module_reset, ports_hiz},
      {28'h000_0000, o});
  endtask

  // watchdog, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd(pdmc_pkg::SYSCTL_ADDR, pdmc_pkg::SYSCTL_RESET, 1'b0);
    rd(16'hffc0, 8'h00, 1'b1);
    i_core.pulse(2);
    rd(pdmc_pkg::SYSCTL_ADDR, 8'h01, 1'b0);
    apb(pdmc_pkg::SYSCTL_ADDR, 1'b1, 8'hff, 4'hf);
    rd(pdmc_pkg::SYSCTL_ADDR, 8'hf7, 1'b0);
    check({29'h0, ram_enable, host_if_enable, nmi_rising_edge}, 32'h7);
    apb(pdmc_pkg::SYSCTL_ADDR, 1'b1, 8'h00, 4'he);
    rd(pdmc_pkg::SYSCTL_ADDR, 8'hf7, 1'b0);
    apb(pdmc_pkg::SYSCTL_ADDR, 1'b1, 8'h00, 4'hf);
    // sleep keeps the clock, halts the core, exits on interrupt
    i_core.halt();
    mode_chk(3'h1, 4'hc);
    i_core.pulse(0);
    mode_chk(3'h0, 4'h4);
    check({31'h0, irq_exception}, 32'h1);
    // reset pin ends sleep into the reset state
    i_core.halt();
    i_core.pins(1'b0, 1'b1);
    // pin is sampled one edge later, the flop shows it the edge after
    repeat (2) @(posedge clk);
    check({31'h0, cpu_reset}, 32'h1);
    i_core.pins(1'b1, 1'b1);
    rd(pdmc_pkg::SYSCTL_ADDR, 8'h09, 1'b0);
    // standby pin from sleep, halt ignored while there
    i_core.halt();
    i_core.pins(1'b1, 1'b0);
    // let the design sample the new pin level first
    @(posedge clk);
    mode_chk(3'h4, 4'hb);
    i_core.halt();
    mode_chk(3'h4, 4'hb);
    i_core.pins(1'b1, 1'b1);
    i_core.pins(1'b0, 1'b1);
    i_core.pins(1'b1, 1'b1);
    rd(pdmc_pkg::SYSCTL_ADDR, 8'h09, 1'b0);
    // software standby through every settle code
    for (int c = 0; c < 8; c++) begin
      // software sets the settle code right before halt
      apb(pdmc_pkg::SYSCTL_ADDR, 1'b1, {1'b1, 3'(c), 4'h0}, 4'hf);
      i_core.halt();
      mode_chk(3'h2, 4'ha);
      check({31'h0, timer_div_limit}, {31'h0, c == 5});
      check({31'h0, osc_en}, 32'h0);
      i_core.pulse(1);
      n = 0;
      held = 1'b1;
      do begin
        @(posedge clk);
        if (power_state === 3'h3) begin
          n++;
          held &= osc_en & cpu_halt & module_reset & ~sys_clk_en;
        end
      end while (power_state !== 3'h0 && n < 400);
      check(32'(n), 32'(settle_n(3'(c)) + 1));
      check({31'h0, held}, 32'h1);
      check({31'h0, irq_exception, sys_clk_en}, 32'h3);
      rd(pdmc_pkg::SYSCTL_ADDR, {1'b1, 3'(c), 4'h8}, 1'b0);
      // restore code 000 once the wake-up is over
      apb(pdmc_pkg::SYSCTL_ADDR, 1'b1, 8'h00, 4'hf);
    end
    close_out();
  end
endmodule

// *** pdmc_top.sv ***
// power-down mode controller with apb access to system_control
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module pdmc_top #(
  parameter int SETTLE_BASE = pdmc_pkg::SETTLE_BASE_CYCLES, // code 000
  parameter int SETTLE_SHORT = pdmc_pkg::SETTLE_SHORT_CYCLES, // code 101
  parameter bit FLASH_VARIANT = 1'b1 // flash-equipped part
) (
  input wire logic clk, // system clock, 10 mhz
  input wire logic reset_n, // synchronous reset, low active
  input wire logic [15:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic halt_strobe, // core executed halt, one cycle
  input wire logic irq_pending, // any enabled interrupt request
  input wire logic ext_wake, // external wake interrupt request
  input wire logic int_reset_event, // reset from an internal source
  input wire logic reset_pin_n, // reset pin, low active
  input wire logic standby_pin_n, // standby pin, low active
  output logic cpu_halt, // core stopped, registers held
  output logic cpu_reset, // core held in reset
  output logic sys_clk_en, // system clock gate enable
  output logic osc_en, // oscillator running
  output logic module_reset, // on-chip modules held at reset
  output logic ports_hiz, // i/o ports to high impedance
  output logic irq_exception, // start interrupt handling, pulse
  output logic ram_enable, // ram enable bit
  output logic host_if_enable, // host interface enable bit
  output logic nmi_rising_edge, // edge select bit for the nmi pin
  output logic timer_div_limit, // slow timer divisors miscount
  output logic [2:0] power_state // current mode
);

  pdmc_pkg::pdmc_sysctl_s sysctl; // system_control register
  pdmc_pkg::pdmc_sysctl_s next_sysctl;
  pdmc_pkg::pdmc_state_e state; // controller mode
  pdmc_pkg::pdmc_state_e next_state;

  // apb answer flops
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // control outputs
  logic next_cpu_halt;
  logic next_cpu_reset;
  logic next_sys_clk_en;
  logic next_osc_en;
  logic next_module_reset;
  logic next_ports_hiz;
  logic next_irq_exception;
  logic next_timer_div_limit;

  logic settle_start; // pulse, wake seen in software standby
  logic settle_busy; // wait running
  logic settle_done; // wait over

  logic hit; // address decodes to system_control
  logic setup; // apb setup cycle
  logic wr_take; // write commits this edge
  logic [2:0] settle_code; // settle field as a vector

  assign hit = (paddr == pdmc_pkg::SYSCTL_ADDR);
  assign setup = psel && !penable;
  assign wr_take = psel && penable && pready && pwrite && hit;
  assign settle_code = {sysctl.settle_sel_2, sysctl.settle_sel_1,
                        sysctl.settle_sel_0};

  // settle wait counter
  pdmc_settle #(
    .BASE_CYCLES(SETTLE_BASE),
    .SHORT_CYCLES(SETTLE_SHORT),
    .FLASH_VARIANT(FLASH_VARIANT)
  ) u_settle (
    .clk(clk),
    .reset_n(reset_n),
    .start(settle_start),
    .code(settle_code),
    .busy(settle_busy),
    .done(settle_done)
  );

  // apb slave: answer registered in setup, one-cycle access phase
  always_comb begin
    next_pready = setup;
    next_pslverr = setup && !hit;
    next_prdata = prdata;
    if (setup) begin
      next_prdata = '0;
      if (hit && !pwrite) begin
        next_prdata[7:0] = sysctl; // upper bits read zero
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // register next value: software writes, pin resets, source flag
  always_comb begin
    next_sysctl = sysctl;
    if (!standby_pin_n || !reset_pin_n) begin
      // hardware standby and pin reset both load initial values
      next_sysctl = pdmc_pkg::SYSCTL_RESET; // R10 R13
    end else begin
      if (wr_take && pstrb[0]) begin
        // reset source flag is read-only, keep it out of the write
        next_sysctl = pwdata[7:0]; // R03 R10
        next_sysctl.reset_source_flag = sysctl.reset_source_flag;
      end
      if (int_reset_event) begin
        next_sysctl.reset_source_flag = 1'b0;
      end
    end
    // standby select is never cleared by wake-up, only by a write, the reset or standby pin, or reset_n
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sysctl <= pdmc_pkg::SYSCTL_RESET; // R10
    end else begin
      sysctl <= next_sysctl;
    end
  end

  // mode sequencing; standby pin first, then reset pin, then events
  always_comb begin
    next_state = state;
    settle_start = 1'b0;
    next_irq_exception = 1'b0;
    if (!standby_pin_n) begin
      next_state = pdmc_pkg::ST_HW_STANDBY; // R13
    end else if (!reset_pin_n) begin
      next_state = pdmc_pkg::ST_RUN; // R11
    end else begin
      case (state)
        pdmc_pkg::ST_RUN: begin
          if (halt_strobe) begin
            // select bit sampled on the halt strobe itself
            if (sysctl.standby_select_bit) begin // R14
              next_state = pdmc_pkg::ST_SW_STANDBY; // R02
            end else begin
              next_state = pdmc_pkg::ST_SLEEP; // R01
            end
          end
        end
        pdmc_pkg::ST_SLEEP: begin
          if (irq_pending) begin
            next_state = pdmc_pkg::ST_RUN; // R11
            next_irq_exception = 1'b1;
          end
        end
        pdmc_pkg::ST_SW_STANDBY: begin
          if (ext_wake) begin
            next_state = pdmc_pkg::ST_SETTLE; // R12
            settle_start = 1'b1; // R04
          end
        end
        pdmc_pkg::ST_SETTLE: begin
          if (settle_done) begin
            next_state = pdmc_pkg::ST_RUN; // R12
            next_irq_exception = 1'b1;
          end
        end
        pdmc_pkg::ST_HW_STANDBY: begin
          // leaving needs the reset pin, handled above
          next_state = pdmc_pkg::ST_HW_STANDBY;
        end
        default: begin
          next_state = pdmc_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= pdmc_pkg::ST_RUN;
      irq_exception <= 1'b0;
    end else begin
      state <= next_state;
      irq_exception <= next_irq_exception;
    end
  end

  // clock, reset and port controls follow the next mode,
  // so they line up with the state flop in the same cycle
  always_comb begin
    next_cpu_halt = 1'b1;
    next_cpu_reset = !reset_pin_n && standby_pin_n;
    next_sys_clk_en = 1'b0;
    next_osc_en = 1'b0;
    next_module_reset = 1'b1;
    next_ports_hiz = 1'b0;
    case (next_state)
      pdmc_pkg::ST_RUN: begin
        next_cpu_halt = next_cpu_reset;
        next_sys_clk_en = 1'b1;
        next_osc_en = 1'b1;
        next_module_reset = next_cpu_reset;
      end
      pdmc_pkg::ST_SLEEP: begin
        next_sys_clk_en = 1'b1; // R01
        next_osc_en = 1'b1;
        next_module_reset = 1'b0;
      end
      pdmc_pkg::ST_SW_STANDBY: begin
        // clock stopped, modules reset; ram and ports untouched
        next_sys_clk_en = 1'b0; // R02
      end
      pdmc_pkg::ST_SETTLE: begin
        next_osc_en = 1'b1; // R04
      end
      pdmc_pkg::ST_HW_STANDBY: begin
        next_ports_hiz = 1'b1; // R13
      end
      default: begin
        next_module_reset = 1'b1;
      end
    endcase
    // short settle leaves slow timer prescalers out of step
    next_timer_div_limit = FLASH_VARIANT &&
      next_sysctl.settle_sel_2 && !next_sysctl.settle_sel_1 &&
      next_sysctl.settle_sel_0; // R08
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cpu_halt <= 1'b0;
      cpu_reset <= 1'b0;
      sys_clk_en <= 1'b1;
      osc_en <= 1'b1;
      module_reset <= 1'b0;
      ports_hiz <= 1'b0;
      timer_div_limit <= 1'b0;
    end else begin
      cpu_halt <= next_cpu_halt;
      cpu_reset <= next_cpu_reset;
      sys_clk_en <= next_sys_clk_en;
      osc_en <= next_osc_en;
      module_reset <= next_module_reset;
      ports_hiz <= next_ports_hiz;
      timer_div_limit <= next_timer_div_limit;
    end
  end

  // plain register bits and mode shown from flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ram_enable <= 1'b1;
      host_if_enable <= 1'b0;
      nmi_rising_edge <= 1'b0;
      power_state <= 3'h0;
    end else begin
      ram_enable <= next_sysctl.ram_enable_bit;
      host_if_enable <= next_sysctl.host_interface_enable;
      nmi_rising_edge <= next_sysctl.nonmaskable_edge_select;
      power_state <= 3'(next_state);
    end
  end

  AST_SLEEP_ENTRY: assert property ( // R01
    @(posedge clk) disable iff (!reset_n)
    state == pdmc_pkg::ST_RUN && halt_strobe && reset_pin_n &&
    standby_pin_n && !sysctl.standby_select_bit
    |=> state == pdmc_pkg::ST_SLEEP && sys_clk_en && cpu_halt &&
        !module_reset)
    else $error("halt did not enter sleep");

  AST_SWSTBY_ENTRY: assert property ( // R02
    @(posedge clk) disable iff (!reset_n)
    state == pdmc_pkg::ST_RUN && halt_strobe && reset_pin_n &&
    standby_pin_n && sysctl.standby_select_bit
    |=> state == pdmc_pkg::ST_SW_STANDBY && !sys_clk_en &&
        module_reset && !ports_hiz)
    else $error("halt did not enter software standby");

  AST_SELECT_KEPT: assert property ( // R03
    @(posedge clk) disable iff (!reset_n)
    state == pdmc_pkg::ST_SETTLE && settle_done && !wr_take &&
    reset_pin_n && standby_pin_n
    |=> sysctl.standby_select_bit)
    else $error("select bit lost on wake-up");

  AST_SETTLE_HOLD: assert property ( // R04
    @(posedge clk) disable iff (!reset_n)
    state == pdmc_pkg::ST_SETTLE |-> osc_en && !sys_clk_en &&
    cpu_halt && module_reset && settle_busy || settle_done)
    else $error("settle wait not held in standby");

  AST_DIV_LIMIT: assert property ( // R08
    @(posedge clk) disable iff (!reset_n)
    ##1 timer_div_limit == (FLASH_VARIANT &&
        {sysctl.settle_sel_2, sysctl.settle_sel_1, sysctl.settle_sel_0}
        == pdmc_pkg::SETTLE_CODE_SHORT))
    else $error("timer limit flag wrong");

  AST_READ_BACK: assert property ( // R10
    @(posedge clk) disable iff (!reset_n)
    setup && hit && !pwrite
    |=> pready && prdata == {24'h00_0000, $past(sysctl)})
    else $error("register read back wrong");

  AST_SLEEP_EXIT: assert property ( // R11
    @(posedge clk) disable iff (!reset_n)
    state == pdmc_pkg::ST_SLEEP && irq_pending && reset_pin_n &&
    standby_pin_n
    |=> state == pdmc_pkg::ST_RUN && irq_exception && !cpu_halt)
    else $error("interrupt did not end sleep");

  AST_WAKE_SEQ: assert property ( // R12
    @(posedge clk) disable iff (!reset_n)
    state == pdmc_pkg::ST_SW_STANDBY && ext_wake && reset_pin_n &&
    standby_pin_n
    |=> state == pdmc_pkg::ST_SETTLE ##1 settle_busy)
    else $error("wake did not start settle wait");

  AST_HW_STANDBY: assert property ( // R13
    @(posedge clk) disable iff (!reset_n)
    !standby_pin_n |=> state == pdmc_pkg::ST_HW_STANDBY && ports_hiz &&
    sysctl == pdmc_pkg::SYSCTL_RESET)
    else $error("standby pin not obeyed");

endmodule
